// File: hw/rrt_pkg.sv
package rrt_pkg;

	// Setpoint and measurement word width, millivolts
	localparam int VW = 16;
	// Duty word width, fraction of full scale
	localparam int DW = 12;

	// Clock and tick timing
	localparam int CLK_HZ          = 250_000_000;
	localparam int TICK_HZ         = 10_000;
	localparam int TICK_CYCLES     = CLK_HZ / TICK_HZ;
	// Tracking hysteresis in millivolts
	localparam logic [VW-1:0] TRACK_HYST_MV = 16'h0014;
	// Reset values
	localparam logic [VW-1:0] SETPOINT_RST  = 16'h0000;
	localparam logic [DW-1:0] DUTY_RST      = 12'h000;

	// Loop coefficient bank selection
	typedef enum logic [1:0] {
		RRT_BANK_RAMP,
		RRT_BANK_NORMAL,
		RRT_BANK_LIGHT
	} rrt_bank_t;

	// Response to a supply fault
	typedef enum logic [1:0] {
		RRT_FAULT_CONTINUE,
		RRT_FAULT_CONTINUE_DELAY,
		RRT_FAULT_SHUTDOWN
	} rrt_fault_act_t;

	// Per-rail ramp configuration
	typedef struct packed {
		logic [VW-1:0] target_mv;
		logic [15:0]   start_wait_time;
		logic [15:0]   start_ramp_time;
		logic [15:0]   stop_wait_time;
		logic [15:0]   stop_ramp_time;
		logic [DW-1:0] min_pulse_duty;
		logic [VW-1:0] min_pulse_mv;
		logic          sole_driver;
		logic [DW-1:0] prebias_gain;
		logic [DW-1:0] prebias_offset;
	} rrt_cfg_t;

	// Tracking configuration
	typedef struct packed {
		logic          enable;
		logic [1:0]    master_sel;
		logic [7:0]    ratio;
	} rrt_track_t;

	// Input supply supervision
	typedef struct packed {
		logic          below_stop;
		logic          below_fault;
		rrt_fault_act_t action;
	} rrt_supply_t;

	// Duty needed to hold a voltage: vout over vin, trimmed
	function automatic logic [DW-1:0] rrt_duty(
		input logic [VW-1:0] vout,
		input logic [VW-1:0] vin,
		input logic [DW-1:0] gain,
		input logic [DW-1:0] offset
	);
		logic [VW+DW-1:0] num;
		logic [VW+DW-1:0] q;
		logic [VW+2*DW-1:0] g;
		num = {vout, {DW{1'b0}}};
		q = (vin == '0) ? '0 : num / {{DW{1'b0}}, vin};
		g = (q * {{VW{1'b0}}, gain}) >> (DW - 1);
		g = g + {{(VW+DW){1'b0}}, offset};
		rrt_duty = (g > {{(VW+DW){1'b0}}, {DW{1'b1}}}) ? {DW{1'b1}} : g[DW-1:0];
	endfunction : rrt_duty

endpackage : rrt_pkg

// File: hw/rrt_rail_ctrl.sv
// Function
// RQ1 - Load loop bank matching operating mode
// RQ2 - Wait start time, then ramp reference
// RQ3 - Outputs off until prebias and min pulse
// RQ4 - Sole driver: rectifier on until min-pulse voltage
// RQ5 - Shared rail: rectifier off at stop start
// RQ6 - Idle: outputs off, setpoint tracks sense
// RQ7 - Prebias duty from vout/vin, trimmed
// RQ8 - Delay enabling until duty exceeds minimum
// RQ9 - Step setpoint on fixed 10 kHz tick
// RQ10 - Regulation after wait plus ramp time
// RQ11 - Normal ramp slews at precomputed rate
// RQ12 - Saturation overrides ramp toward smaller error
// RQ13 - Supply stop level starts soft stop
// RQ14 - Supply fault applies configured action
// RQ15 - Tracking follows internal rail or external
// RQ16 - Above target: stop following, regulate
// RQ17 - Below target minus 20 mV: resume
// RQ18 - Tracking slew limited below saturation
// RQ19 - Foldback or saturation departs tracking
// RQ20 - Tracking enable and master per rail
// RQ21 - Ratio scales master voltage
// RQ22 - Stop wait then stop ramp time
// RQ23 - Host starts rail by pin or command
// RQ24 - Step equals span over ticks left
`timescale 1ns/1ps
`default_nettype none
module rrt_rail_ctrl
	import rrt_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
)
(
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic          rail_on,
	input  wire rrt_pkg::rrt_cfg_t   cfg,
	input  wire rrt_pkg::rrt_track_t trk,
	input  wire rrt_pkg::rrt_supply_t supply,
	input  wire logic          light_load,
	input  wire logic          foldback,
	input  wire logic          sampler_sat,
	input  wire logic          sampler_sat_neg,
	input  wire logic [VW-1:0] sense_mv,
	input  wire logic [VW-1:0] vin_mv,
	input  wire logic [VW-1:0] ext_follow_mv,
	input  wire logic [VW-1:0] rail0_mv,
	input  wire logic [VW-1:0] rail1_mv,
	input  wire logic [VW-1:0] rail2_mv,
	input  wire logic [VW-1:0] track_slew_max,
	output logic      [VW-1:0] setpoint,
	output logic               pulse_width_outputs,
	output logic               rectifier_enable_out,
	output rrt_pkg::rrt_bank_t loop_coefficient_sets,
	output logic               in_regulation,
	output logic               idle
);
	typedef enum logic [2:0] {
		RRT_IDLE,
		RRT_START_WAIT,
		RRT_RAMP_UP,
		RRT_REGULATE,
		RRT_STOP_WAIT,
		RRT_RAMP_DOWN
	} rrt_state_t;

	rrt_state_t         state;
	rrt_state_t         next_state;
	logic [31:0]        tick_cnt;
	logic               tick;
	logic [15:0]        wait_cnt;
	logic [15:0]        ticks_left;
	logic               following;
	logic               shutdown;
	logic [VW-1:0]      step;

	wire [VW-1:0] master_mv;
	wire [VW+7:0] scaled_full;
	wire [VW-1:0] track_ref;
	wire [VW-1:0] goal;
	wire [VW-1:0] span;
	wire [DW-1:0] ramp_duty;
	wire          ramp_up;
	wire          ramp_dn;
	wire          drive_ok;
	wire          want_off;
	wire [VW-1:0] trk_delta;
	wire [VW-1:0] trk_step;

	// Ten kilohertz update enable from the system clock
	// RQ9 fixed tick rate
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end
		else
		begin
			tick     <= (tick_cnt == 32'(TICK_DIV - 1));
			tick_cnt <= (tick_cnt == 32'(TICK_DIV - 1)) ? '0 : tick_cnt + 32'h1;
		end
	end

	// Master select and ratio scaling
	// RQ15 master select
	assign master_mv   = (trk.master_sel == 2'h0) ? ext_follow_mv :
	                     (trk.master_sel == 2'h1) ? rail0_mv :
	                     (trk.master_sel == 2'h2) ? rail1_mv : rail2_mv;
	// RQ21 ratio scaling
	assign scaled_full = ({8'h00, master_mv} * {{VW{1'b0}}, trk.ratio}) >> 7;
	assign track_ref   = (scaled_full > {8'h00, {VW{1'b1}}}) ? {VW{1'b1}}
	                                                         : scaled_full[VW-1:0];

	// Ramp goal and span; goal is SETPOINT_RST when ramping down, else target_mv
	assign ramp_up  = (state == RRT_RAMP_UP);
	assign ramp_dn  = (state == RRT_RAMP_DOWN);
	assign goal     = ramp_dn ? SETPOINT_RST : cfg.target_mv;
	assign span     = (goal > setpoint) ? goal - setpoint : setpoint - goal;

	// RQ7 prebias duty
	assign ramp_duty = rrt_duty(setpoint, vin_mv, cfg.prebias_gain, cfg.prebias_offset);
	// RQ3 prebias and minimum pulse
	// RQ8 postpone until duty ok
	assign drive_ok  = (setpoint >= sense_mv) && (ramp_duty > cfg.min_pulse_duty);

	// Tracking steps are clipped so the sampler stays in range
	// RQ18 tracking slew limit
	assign trk_delta = (track_ref > setpoint) ? track_ref - setpoint : setpoint - track_ref;
	assign trk_step  = (trk_delta > track_slew_max) ? track_slew_max : trk_delta;

	// RQ23 host request by pin or command
	// RQ13 supply stop level
	assign want_off = !rail_on || supply.below_stop;

	// RQ24 step from span and ticks left
	rrt_step_calc u_step (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.span       (span),
		.ticks_left (ticks_left),
		.step       (step)
	);

	// Sequencer state
	always_comb
	begin
		next_state = state;
		case (state)
			RRT_IDLE:
				if (!want_off && !shutdown)
					next_state = RRT_START_WAIT;
			// RQ2 start wait
			RRT_START_WAIT:
				if (want_off)
					next_state = RRT_IDLE;
				else if (tick && wait_cnt == 16'h0)
					next_state = RRT_RAMP_UP;
			// RQ10 finish at wait plus ramp
			RRT_RAMP_UP:
				if (want_off)
					next_state = RRT_STOP_WAIT;
				else if (tick && ticks_left <= 16'h1 && !trk.enable)
					next_state = RRT_REGULATE;
				else if (tick && trk.enable && setpoint >= cfg.target_mv)
					next_state = RRT_REGULATE;
			RRT_REGULATE:
				if (want_off)
					next_state = RRT_STOP_WAIT;
			// RQ22 stop wait
			RRT_STOP_WAIT:
				if (!want_off)
					next_state = RRT_REGULATE;
				else if (tick && wait_cnt == 16'h0)
					next_state = RRT_RAMP_DOWN;
			RRT_RAMP_DOWN:
				if (tick && (ticks_left <= 16'h1 || setpoint == SETPOINT_RST))
					next_state = RRT_IDLE;
			default:
				next_state = RRT_IDLE;
		endcase
		// RQ14 immediate shutdown
		if (shutdown)
			next_state = RRT_IDLE;
	end

	// Supply fault action; shutdown latches until the request drops with the fault clear
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			shutdown <= 1'b0;
		// RQ14 configured action
		else if (supply.below_fault && supply.action == RRT_FAULT_SHUTDOWN)
			shutdown <= 1'b1;
		else if (!rail_on && !supply.below_fault)
			shutdown <= 1'b0;
	end

	// State, wait and tick counters
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state      <= RRT_IDLE;
			wait_cnt   <= '0;
			ticks_left <= '0;
		end
		else
		begin
			state <= next_state;
			if (next_state == RRT_START_WAIT && state != RRT_START_WAIT)
				wait_cnt <= cfg.start_wait_time;
			else if (next_state == RRT_STOP_WAIT && state != RRT_STOP_WAIT)
				wait_cnt <= cfg.stop_wait_time;
			else if (tick && wait_cnt != 16'h0)
				wait_cnt <= wait_cnt - 16'h1;
			// RQ22 stop ramp time
			if (next_state == RRT_RAMP_UP && state != RRT_RAMP_UP)
				ticks_left <= cfg.start_ramp_time;
			else if (next_state == RRT_RAMP_DOWN && state != RRT_RAMP_DOWN)
				ticks_left <= cfg.stop_ramp_time;
			else if (tick && ticks_left != 16'h0)
				ticks_left <= ticks_left - 16'h1;
		end
	end

	// Tracking follow flag with hysteresis
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			following <= 1'b1;
		// RQ16 stop following above target
		else if (track_ref > cfg.target_mv)
			following <= 1'b0;
		// RQ17 resume below hysteresis
		else if (track_ref + TRACK_HYST_MV < cfg.target_mv)
			following <= 1'b1;
	end

	// Setpoint update; saturation recovery beats the scheduled step
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			setpoint <= SETPOINT_RST;
		else if (state == RRT_IDLE)
			// RQ6 setpoint follows sense
			setpoint <= sense_mv;
		else if (tick && (ramp_up || ramp_dn || state == RRT_REGULATE))
		begin
			// RQ12 saturation override
			// RQ19 depart on saturation
			if (sampler_sat)
				setpoint <= sampler_sat_neg ? setpoint - 16'h1 : setpoint + 16'h1;
			// RQ19 depart on foldback
			else if (foldback)
				setpoint <= setpoint;
			// RQ20 per-rail tracking enable
			else if (trk.enable && following && !ramp_dn)
				setpoint <= (track_ref > setpoint) ? setpoint + trk_step
				                                   : setpoint - trk_step;
			else if (trk.enable && !ramp_dn)
				setpoint <= cfg.target_mv;
			// RQ11 precomputed slew
			else if (ramp_up)
				setpoint <= (setpoint + step > goal) ? goal : setpoint + step;
			else if (ramp_dn)
				setpoint <= (step > setpoint) ? SETPOINT_RST : setpoint - step;
		end
	end

	// Drive outputs and bank selection
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pulse_width_outputs   <= 1'b0;
			rectifier_enable_out  <= 1'b0;
			loop_coefficient_sets <= RRT_BANK_RAMP;
			in_regulation         <= 1'b0;
			idle                  <= 1'b1;
		end
		else
		begin
			idle          <= (next_state == RRT_IDLE);
			in_regulation <= (next_state == RRT_REGULATE);
			// RQ6 idle outputs off
			if (next_state == RRT_IDLE || next_state == RRT_START_WAIT)
			begin
				pulse_width_outputs  <= 1'b0;
				rectifier_enable_out <= 1'b0;
			end
			// RQ3 enable once drive ok
			else if (ramp_up && drive_ok)
			begin
				pulse_width_outputs  <= 1'b1;
				rectifier_enable_out <= 1'b1;
			end
			// RQ5 shared rail stop
			else if (ramp_dn && !cfg.sole_driver)
				rectifier_enable_out <= 1'b0;
			// RQ4 sole driver stop
			else if (ramp_dn && setpoint <= cfg.min_pulse_mv)
			begin
				rectifier_enable_out <= 1'b0;
				pulse_width_outputs  <= 1'b0;
			end
			// RQ1 bank per mode
			// Keyed on the state being entered so it moves with in_regulation
			if (next_state == RRT_RAMP_UP || next_state == RRT_RAMP_DOWN ||
				(trk.enable && following))
				loop_coefficient_sets <= RRT_BANK_RAMP;
			else if (light_load)
				loop_coefficient_sets <= RRT_BANK_LIGHT;
			else
				loop_coefficient_sets <= RRT_BANK_NORMAL;
		end
	end
endmodule : rrt_rail_ctrl
`default_nettype wire

// File: hw/rrt_step_calc.sv
`timescale 1ns/1ps
`default_nettype none
// Registered ramp step: remaining span over remaining ticks
module rrt_step_calc
	import rrt_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic [VW-1:0] span,
	input  wire logic [15:0]   ticks_left,
	output logic      [VW-1:0] step
);
	wire [VW-1:0] next_step;

	// Last tick takes the whole remainder so the ramp lands on time
	assign next_step = (ticks_left <= 16'h0001) ? span : VW'(span / ticks_left);

	// Registered to keep the divider off the ramp update path
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			step <= SETPOINT_RST;
		else
			step <= next_step;
	end
endmodule : rrt_step_calc
`default_nettype wire

// File: sim/rrt_rail_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rrt_chk
	import rrt_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
)
(
	input wire logic                 clk_sys,
	input wire logic                 rst_n,
	input wire logic                 rail_on,
	input wire rrt_pkg::rrt_cfg_t    cfg,
	input wire rrt_pkg::rrt_track_t  trk,
	input wire rrt_pkg::rrt_supply_t supply,
	input wire logic                 light_load,
	input wire logic                 sampler_sat,
	input wire logic [VW-1:0]        sense_mv,
	input wire logic [VW-1:0]        setpoint,
	input wire logic                 pulse_width_outputs,
	input wire logic                 rectifier_enable_out,
	input wire rrt_pkg::rrt_bank_t   loop_coefficient_sets,
	input wire logic                 in_regulation,
	input wire logic                 idle
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	int   run;
	int   lo;
	logic sat_seen;
	// Start window; a saturation event may stretch the ramp
	assign lo = (int'(cfg.start_wait_time) + int'(cfg.start_ramp_time)) * TICK_DIV;
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			run <= 0;
			sat_seen <= 1'b0;
		end
		else
		begin
			run <= idle ? 0 : run + 1;
			sat_seen <= !idle && (sat_seen || sampler_sat);
		end
	chk_idle_quiet: assert property (idle |-> !pulse_width_outputs && !rectifier_enable_out)
		else $error("drive active while idle");
	chk_enable_prebias: assert property ($rose(pulse_width_outputs) |->
		$past(setpoint) >= $past(sense_mv)) else $error("drive enabled below prebias");
	chk_sole_hold: assert property (cfg.sole_driver && !rail_on && !supply.below_fault &&
		$fell(rectifier_enable_out) |-> setpoint <= cfg.min_pulse_mv)
		else $error("rectifier dropped early");
	chk_shared_stop: assert property (!cfg.sole_driver && !rail_on && !idle &&
		setpoint < $past(setpoint) |-> !rectifier_enable_out) else $error("rectifier on in stop");
	chk_tick_pace: assert property (!idle && !$past(idle) && $changed(setpoint) |=>
		($stable(setpoint) || idle) [*8]) else $error("setpoint off tick");
	chk_start_time: assert property ($rose(in_regulation) && !sat_seen && !trk.enable |->
		run >= lo && run <= lo + 2 * TICK_DIV) else $error("regulation time wrong");
	chk_sat_step: assert property (sampler_sat && $past(sampler_sat) && !idle &&
		!in_regulation && $changed(setpoint) |-> setpoint == $past(setpoint) + 16'h0001 ||
		setpoint + 16'h0001 == $past(setpoint)) else $error("saturation step wrong");
	chk_fault_off: assert property (supply.below_fault &&
		supply.action == RRT_FAULT_SHUTDOWN |-> ##[0:12] !pulse_width_outputs &&
		!rectifier_enable_out) else $error("fault left drive on");
	chk_reg_bank: assert property ($rose(in_regulation) && !light_load && !trk.enable |->
		loop_coefficient_sets == RRT_BANK_NORMAL) else $error("bank not normal");
endmodule : rrt_chk
bind rrt_rail_ctrl rrt_chk #(.TICK_DIV(TICK_DIV)) i_rrt_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.rail_on(rail_on), .cfg(cfg), .trk(trk), .supply(supply), .light_load(light_load),
	.sampler_sat(sampler_sat), .sense_mv(sense_mv), .setpoint(setpoint),
	.pulse_width_outputs(pulse_width_outputs), .rectifier_enable_out(rectifier_enable_out),
	.loop_coefficient_sets(loop_coefficient_sets), .in_regulation(in_regulation), .idle(idle));
`default_nettype wire

// File: sim/rrt_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module rrt_stage_model
	import rrt_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          pulse_on,
	input  wire logic [VW-1:0] setpoint,
	input  wire logic          slow,
	input  wire logic          pre_load,
	input  wire logic [VW-1:0] pre_mv,
	output logic      [VW-1:0] sense_mv
);
	// Output cap holds its charge while not switching
	always_ff @(posedge clk_sys)
		if (pre_load)
			sense_mv <= pre_mv;
		else if (pulse_on)
			sense_mv <= slow ? VW'((17'(sense_mv) + 17'(setpoint)) >> 1) : setpoint;
endmodule : rrt_stage_model
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import rrt_pkg::*;
;
	localparam int T = 10;
	logic          clk_sys = 1'b0;
	logic          rst_n = 1'b0;
	logic          rail_on = 1'b0;
	rrt_cfg_t      cfg = '0;
	rrt_track_t    trk = '0;
	rrt_supply_t   supply = '0;
	logic          light_load = 1'b0;
	logic          sat = 1'b0;
	logic          sat_neg = 1'b0;
	logic          fold = 1'b0;
	logic [VW-1:0] slew = 16'hffff;
	logic          slow = 1'b0;
	logic          pre_load = 1'b1;
	logic [VW-1:0] pre_mv = '0;
	logic [VW-1:0] ext_mv = '0;
	logic [VW-1:0] rail_mv = '0;
	logic [VW-1:0] sense_mv;
	logic [VW-1:0] setpoint;
	logic          pwm;
	logic          rect;
	rrt_bank_t     bank;
	logic          in_reg;
	logic          idle;
	int            fails = 0;
	int            checks_done = 0;
	always #2 clk_sys = ~clk_sys;
	rrt_rail_ctrl #(.TICK_DIV(T)) i_rrt_rail_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
		.rail_on(rail_on), .cfg(cfg), .trk(trk), .supply(supply), .light_load(light_load),
		.foldback(fold), .sampler_sat(sat), .sampler_sat_neg(sat_neg), .sense_mv(sense_mv),
		.vin_mv(16'h2ee0), .ext_follow_mv(ext_mv), .rail0_mv(rail_mv),
		.rail1_mv(rail_mv + 16'h0010), .rail2_mv(rail_mv + 16'h0020),
		.track_slew_max(slew), .setpoint(setpoint), .pulse_width_outputs(pwm),
		.rectifier_enable_out(rect), .loop_coefficient_sets(bank), .in_regulation(in_reg),
		.idle(idle));
	rrt_stage_model i_rrt_stage_model (.clk_sys(clk_sys), .pulse_on(pwm), .setpoint(setpoint),
		.slow(slow), .pre_load(pre_load), .pre_mv(pre_mv), .sense_mv(sense_mv));
	task automatic end_sim;
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	task automatic cmp_mv(input logic [VW-1:0] got, input logic [VW-1:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: mv %0d not %0d", $time, got, exp);
		end
	endtask : cmp_mv
	task automatic cmp_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: flag %b", $time, got);
		end
	endtask : cmp_bit
	task automatic cmp_bank(input rrt_bank_t got, input rrt_bank_t exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: bank %0d", $time, got);
		end
	endtask : cmp_bank
	// Bounded wait: 0 regulation, 1 idle, 2 drive on
	task automatic await(input int what);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 4000 && !hit; i++)
		begin
			@(negedge clk_sys);
			hit = (what == 0 && in_reg === 1'b1) || (what == 1 && idle === 1'b1) ||
				(what == 2 && pwm === 1'b1);
		end
		// A wait that runs out is a mismatch, not a silent pass
		if (!hit)
		begin
			fails++;
			$display("wrong value at %0t: wait ran out", $time);
		end
	endtask : await
	task automatic expect_sp(input logic [VW-1:0] exp);
		for (int i = 0; i < 600 && setpoint !== exp; i++)
			@(negedge clk_sys);
		cmp_mv(setpoint, exp);
	endtask : expect_sp
	task automatic ticks(input int n);
		repeat (n * T) @(negedge clk_sys);
	endtask : ticks
	// Watchdog well beyond the few thousand cycles needed
	initial
	begin
		#100us;
		fails++;
		end_sim();
	end
	initial
	begin
		cfg.target_mv = 16'h03e8;
		cfg.start_wait_time = 16'h0002;
		cfg.start_ramp_time = 16'h0008;
		cfg.stop_wait_time = 16'h0001;
		cfg.stop_ramp_time = 16'h0008;
		cfg.min_pulse_duty = 12'h010;
		cfg.min_pulse_mv = 16'h0064;
		cfg.prebias_gain = 12'h800;
		repeat (20) @(negedge clk_sys);
		cmp_bit(idle, 1'b1);
		cmp_mv(setpoint, SETPOINT_RST);
		rst_n = 1'b1;
		pre_load = 1'b0;
		@(negedge clk_sys);
		// Plain start on a shared rail; host request is a level
		rail_on = 1'b1;
		await(2);
		cmp_bank(bank, RRT_BANK_RAMP);
		cmp_bit(in_reg, 1'b0);
		await(0);
		cmp_mv(setpoint, cfg.target_mv);
		cmp_bit(rect, 1'b1);
		light_load = 1'b1;
		ticks(3);
		cmp_bank(bank, RRT_BANK_LIGHT);
		light_load = 1'b0;
		rail_on = 1'b0;
		await(1);
		cmp_bit(pwm | rect, 1'b0);
		// Pre-biased start, sole driver, minimum pulse binding
		cfg.sole_driver = 1'b1;
		cfg.min_pulse_duty = 12'h040;
		pre_mv = 16'h0032;
		pre_load = 1'b1;
		ticks(1);
		pre_load = 1'b0;
		expect_sp(16'h0032);
		rail_on = 1'b1;
		await(2);
		cmp_bit(setpoint >= 16'h00bc, 1'b1);
		await(0);
		cmp_mv(setpoint, cfg.target_mv);
		rail_on = 1'b0;
		await(1);
		// Saturation in mid-ramp
		cfg.sole_driver = 1'b0;
		rail_on = 1'b1;
		await(2);
		sat = 1'b1;
		ticks(3);
		sat = 1'b0;
		await(0);
		cmp_mv(setpoint, cfg.target_mv);
		// Tracking at half ratio, with a sluggish stage
		slow = 1'b1;
		ext_mv = 16'h04b0;
		trk = '{1'b1, 2'h0, 8'h40};
		expect_sp(16'h0258);
		cmp_bank(bank, RRT_BANK_RAMP);
		ext_mv = 16'h0bb8;
		expect_sp(cfg.target_mv);
		cmp_bank(bank, RRT_BANK_NORMAL);
		ext_mv = 16'h07b2;
		ticks(5);
		cmp_mv(setpoint, cfg.target_mv);
		ext_mv = 16'h076c;
		expect_sp(16'h03b6);
		rail_mv = 16'h0320;
		trk.ratio = 8'h80;
		for (int m = 1; m < 4; m++)
		begin
			trk.master_sel = 2'(m);
			expect_sp(rail_mv + 16'h0010 * 16'(m - 1));
		end
		// Slew cap, foldback hold and downward saturation while tracking
		slew = 16'h0010;
		trk.master_sel = 2'h1;
		expect_sp(16'h0330);
		expect_sp(rail_mv);
		fold = 1'b1;
		trk.master_sel = 2'h3;
		ticks(3);
		cmp_mv(setpoint, rail_mv);
		fold = 1'b0;
		expect_sp(16'h0340);
		sat = 1'b1;
		sat_neg = 1'b1;
		ticks(3);
		cmp_mv(setpoint, 16'h033d);
		sat = 1'b0;
		sat_neg = 1'b0;
		expect_sp(16'h0340);
		trk.enable = 1'b0;
		slow = 1'b0;
		rail_on = 1'b0;
		await(1);
		// Supply droop: soft stop, tolerated fault, hard fault
		rail_on = 1'b1;
		await(0);
		supply.below_stop = 1'b1;
		await(1);
		cmp_bit(idle, 1'b1);
		supply.below_stop = 1'b0;
		await(0);
		for (int a = 0; a < 2; a++)
		begin
			supply = '{1'b0, 1'b1, rrt_fault_act_t'(a)};
			ticks(3);
			cmp_bit(in_reg, 1'b1);
		end
		supply.action = RRT_FAULT_SHUTDOWN;
		ticks(3);
		cmp_bit(pwm | rect, 1'b0);
		supply = '0;
		ticks(3);
		cmp_bit(pwm, 1'b0);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
